// *** sdb_pkg.sv ***
// Shared constants and types for the DRAM bank-state and clock-enable block.
// Assumes a single 40 MHz command clock; all pins sampled on its rising edge.
package sdb_pkg;

  localparam int CLK_PS         = 25000;
  localparam int T_RP_NS        = 18;
  localparam int T_RCD_NS       = 18;
  localparam int T_RAS_NS       = 42;
  localparam int T_RRD_NS       = 12;
  localparam int T_DPL_NS       = 12;
  localparam int T_RFC_NS       = 66;
  localparam int T_XSR_NS       = 66;
  localparam int T_DPD_EXIT_US  = 100;
  localparam int MRS_CYC        = 2;

  // Least times round up, never below one cycle
  function automatic int min_cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RP_CYC         = min_cyc(T_RP_NS);
  localparam int RCD_CYC        = min_cyc(T_RCD_NS);
  localparam int RAS_CYC        = min_cyc(T_RAS_NS);
  localparam int RRD_CYC        = min_cyc(T_RRD_NS);
  localparam int DPL_CYC        = min_cyc(T_DPL_NS);
  localparam int RFC_CYC        = min_cyc(T_RFC_NS);
  localparam int XSR_CYC        = min_cyc(T_XSR_NS);
  localparam int DPD_CYC        = (T_DPD_EXIT_US * 1000000 + CLK_PS - 1) / CLK_PS;

  localparam int CNT_W          = 12;
  localparam int BCNT_W         = 4;
  localparam int BST_W          = 4;
  localparam int MODE_W         = 10;
  localparam int BL_LSB         = 0;
  localparam int BL_MSB         = 2;
  localparam int WB_BIT         = 9;
  localparam int AUTO_CLOSE_BIT = 10;
  localparam logic [MODE_W-1:0] MODE_RST = 10'h000;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_RD  = 3'h2,
    CMD_WR  = 3'h3,
    CMD_PRE = 3'h4,
    CMD_REF = 3'h5,
    CMD_MRS = 3'h6,
    CMD_DPD = 3'h7
  } sdb_cmd_t;

  typedef enum logic [3:0] {
    BS_IDLE      = 4'h0,
    BS_ACTIVATNG = 4'h1,
    BS_ACTIVE    = 4'h2,
    BS_READ      = 4'h3,
    BS_WRITE     = 4'h4,
    BS_READ_AC   = 4'h5,
    BS_WRITE_AC  = 4'h6,
    BS_WR_REC    = 4'h7,
    BS_WR_REC_AC = 4'h8,
    BS_PRECH     = 4'h9
  } sdb_bank_st_t;

  typedef enum logic [3:0] {
    DS_NORMAL   = 4'h0,
    DS_REFRESH  = 4'h1,
    DS_MRS      = 4'h2,
    DS_SELF_REF = 4'h3,
    DS_SR_EXIT  = 4'h4,
    DS_PWR_DOWN = 4'h5,
    DS_DEEP_PD  = 4'h6,
    DS_DPD_EXIT = 4'h7,
    DS_SUSPEND  = 4'h8
  } sdb_dev_st_t;

endpackage

// *** sdb_bank_if.sv ***
// Carrier between the command decoder and one bank state machine.
// Assumes the decoder forwards every command decoded in the normal state this edge except low-power entries, refused ones included.
`timescale 1ns/1ps
interface sdb_bank_if;
  import sdb_pkg::*;
  logic                en;
  sdb_cmd_t            cmd;
  logic                hit;
  logic                a10;
  logic [BCNT_W-1:0]   bl;
  logic                wr_single;
  sdb_bank_st_t        st;
  logic                ill;
  modport top  (output en, cmd, hit, a10, bl, wr_single, input st, ill);
  modport bank (input en, cmd, hit, a10, bl, wr_single, output st, ill);
endinterface

// *** sdb_bank.sv ***
// One bank: state, burst and recovery timers, per-bank legality.
// Assumes en is the gated internal clock and cmd is already decoded.
`timescale 1ns/1ps
module sdb_bank
  import sdb_pkg::*;
#(
  parameter int RP  = RP_CYC,
  parameter int RCD = RCD_CYC,
  parameter int RAS = RAS_CYC,
  parameter int DPL = DPL_CYC
) (
  input  wire logic clk,
  input  wire logic rst_b,
  sdb_bank_if.bank  b
);
  initial begin
    if (RP < 1 || RP > 15 || RCD < 1 || RCD > 15 || RAS < 1 || RAS > 15 ||
        DPL < 1 || DPL > 15) begin
      $error("sdb_bank: timing counts must be 1 to 15");
    end
  end

  sdb_bank_st_t      st_r;
  sdb_bank_st_t      st_nxt;
  logic [BCNT_W-1:0] cnt_r;
  logic [BCNT_W-1:0] cnt_nxt;
  logic [BCNT_W-1:0] ras_r;
  logic [BCNT_W-1:0] ras_nxt;
  logic              ill;
  logic              go;
  logic              tick;
  logic              last;

  assign b.st  = st_r;
  assign b.ill = ill;

  always_comb begin
    // Burst-stop code with clock enable high is ignored, not refused
    go      = b.en && b.hit && (b.cmd != CMD_NOP) && (b.cmd != CMD_DPD);
    tick    = b.en && (cnt_r != '0);
    last    = tick && (cnt_r == BCNT_W'(1));
    st_nxt  = st_r;
    cnt_nxt = tick ? cnt_r - BCNT_W'(1) : cnt_r;
    ras_nxt = (b.en && ras_r != '0) ? ras_r - BCNT_W'(1) : ras_r;
    ill     = 1'b0;
    // Timer expiry first; an accepted command below overrides it
    case (st_r)
      BS_ACTIVATNG: if (last) st_nxt = BS_ACTIVE;
      BS_READ:      if (last) st_nxt = BS_ACTIVE;
      BS_WRITE, BS_WRITE_AC: begin
        if (last) begin
          st_nxt  = (st_r == BS_WRITE) ? BS_WR_REC : BS_WR_REC_AC;
          cnt_nxt = BCNT_W'(DPL);
        end
      end
      BS_READ_AC: begin
        if (last) begin
          st_nxt  = (RP > 1) ? BS_PRECH : BS_IDLE;
          cnt_nxt = BCNT_W'(RP - 1);
        end
      end
      BS_WR_REC:    if (last) st_nxt = BS_ACTIVE;
      BS_WR_REC_AC: begin
        if (last) begin
          st_nxt  = (RP > 1) ? BS_PRECH : BS_IDLE;
          cnt_nxt = BCNT_W'(RP - 1);
        end
      end
      BS_PRECH:     if (last) st_nxt = BS_IDLE;
      default:      st_nxt = st_r;
    endcase
    if (go) begin
      case (st_r)
        BS_IDLE: begin
          if (b.cmd == CMD_ACT) begin
            st_nxt  = (RCD > 1) ? BS_ACTIVATNG : BS_ACTIVE;
            cnt_nxt = BCNT_W'(RCD - 1);
            ras_nxt = BCNT_W'(RAS - 1);
          end else if (b.cmd == CMD_RD || b.cmd == CMD_WR) begin
            ill = 1'b1;
          end
        end
        BS_ACTIVE, BS_READ, BS_WRITE, BS_WR_REC: begin
          if (b.cmd == CMD_RD || b.cmd == CMD_WR) begin
            if (b.cmd == CMD_RD) begin
              st_nxt  = b.a10 ? BS_READ_AC : BS_READ;
              cnt_nxt = b.bl;
            end else begin
              st_nxt  = b.a10 ? BS_WRITE_AC : BS_WRITE;
              cnt_nxt = b.wr_single ? BCNT_W'(1) : b.bl;
            end
          end else if (b.cmd == CMD_PRE && st_r != BS_WR_REC &&
                       (st_r != BS_ACTIVE || ras_r == '0)) begin
            // Write data not yet recovered must be masked outside
            st_nxt  = (RP > 1) ? BS_PRECH : BS_IDLE;
            cnt_nxt = BCNT_W'(RP - 1);
          end else begin
            ill = 1'b1;
          end
        end
        BS_PRECH: ill = (b.cmd != CMD_PRE);
        default:  ill = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r  <= BS_IDLE;
      cnt_r <= '0;
      ras_r <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      ras_r <= ras_nxt;
    end
  end
endmodule

// *** sdb_ctrl.sv ***
// Command decoder, clock-enable power states and four bank state machines.
// Assumes pins are synchronous to REF_CLK; no register bus is present.
`timescale 1ns/1ps
// Operation
// - Precharge during a plain write burst ends it and begins precharging.
// - A write during a plain write burst restarts the write, optionally auto-close.
// - A read during a plain write burst cuts the write and starts the read.
// - Precharging bank ignores precharge or no-op; idle after precharge period.
// - Activating bank ignores no-op; row-active after activate-to-access delay.
// - Plain write recovery ends in row-active after the write-recovery time.
// - A write during plain write recovery restarts writing, auto-close when address bit high.
// - After mode register access only no-ops; idle two cycles later.
// - Commands decode only when clock enable was high the cycle before.
// - All idle, clock enable falling: refresh enters self refresh, no-op power down.
// - Self refresh exits on clock enable rising; a command other than a no-op there is refused.
// - Deep power down exit needs no-ops for 100 microseconds.
// - In low-power states a high previous clock enable is invalid.
// - Otherwise clock enable low suspends next cycle; rising resumes next cycle.
// - Burst-stop encoding with clock enable falling enters deep power down.
module sdb_ctrl
  import sdb_pkg::*;
#(
  parameter int NUM_BANKS = 4,
  parameter int DPD_EXIT  = DPD_CYC
) (
  input  wire logic                           REF_CLK,
  input  wire logic                           RST_B,
  input  wire logic                           CKE,
  input  wire logic                           CS_B,
  input  wire logic                           RAS_B,
  input  wire logic                           CAS_B,
  input  wire logic                           WE_B,
  input  wire logic [1:0]                     BA,
  input  wire logic [10:0]                    ADDR,
  output logic [NUM_BANKS*sdb_pkg::BST_W-1:0] BANK_STATE,
  output logic [3:0]                          DEV_STATE,
  output logic                                ALL_BANKS_IDLE,
  output logic                                CLK_ACTIVE,
  output logic                                CMD_ILLEGAL
);
  initial begin
    if (NUM_BANKS < 1 || NUM_BANKS > 4) begin
      $error("sdb_ctrl: NUM_BANKS must be 1 to 4");
    end
    if (DPD_EXIT < 2 || DPD_EXIT >= (1 << CNT_W)) begin
      $error("sdb_ctrl: DPD_EXIT out of counter range");
    end
  end

  sdb_dev_st_t         dev_r;
  sdb_dev_st_t         dev_nxt;
  logic [CNT_W-1:0]    cnt_r;
  logic [CNT_W-1:0]    cnt_nxt;
  logic [BCNT_W-1:0]   rrd_r;
  logic [BCNT_W-1:0]   rrd_nxt;
  logic [MODE_W-1:0]   mode_r;
  logic [MODE_W-1:0]   mode_nxt;
  logic                cke_prev_r;
  logic                ill_r;
  logic                ill;
  logic                bank_go;
  logic                all_idle;
  logic                is_nop;
  logic                bank_ill;
  sdb_cmd_t            cmd;
  logic [BCNT_W-1:0]   bl;
  logic [NUM_BANKS-1:0] idle_v;
  logic [NUM_BANKS-1:0] ill_v;

  always_comb begin
    cmd = CMD_NOP;
    if (!CS_B) begin
      case ({RAS_B, CAS_B, WE_B})
        3'b011:  cmd = CMD_ACT;
        3'b101:  cmd = CMD_RD;
        3'b100:  cmd = CMD_WR;
        3'b010:  cmd = CMD_PRE;
        3'b001:  cmd = CMD_REF;
        3'b000:  cmd = CMD_MRS;
        3'b110:  cmd = CMD_DPD;
        default: cmd = CMD_NOP;
      endcase
    end
  end

  // Full page is coded as zero: the burst runs until cut off
  always_comb begin
    case (mode_r[BL_MSB:BL_LSB])
      3'b000:  bl = BCNT_W'(1);
      3'b001:  bl = BCNT_W'(2);
      3'b010:  bl = BCNT_W'(4);
      3'b011:  bl = BCNT_W'(8);
      3'b111:  bl = '0;
      default: bl = BCNT_W'(1);
    endcase
  end

  assign is_nop   = (cmd == CMD_NOP);
  assign all_idle = &idle_v;
  assign bank_ill = |ill_v;

  always_comb begin
    dev_nxt  = dev_r;
    cnt_nxt  = cnt_r;
    mode_nxt = mode_r;
    rrd_nxt  = (cke_prev_r && rrd_r != '0) ? rrd_r - BCNT_W'(1) : rrd_r;
    ill      = 1'b0;
    bank_go  = 1'b0;
    case (dev_r)
      DS_NORMAL: begin
        if (cke_prev_r) begin
          if (!CKE && all_idle && cmd == CMD_REF) begin
            dev_nxt = DS_SELF_REF;
          end else if (!CKE && all_idle && is_nop) begin
            dev_nxt = DS_PWR_DOWN;
          end else if (!CKE && cmd == CMD_DPD) begin
            dev_nxt = DS_DEEP_PD;
            ill     = !all_idle;
          end else begin
            if (!CKE) begin
              dev_nxt = DS_SUSPEND;
            end
            bank_go = 1'b1;
            if (cmd == CMD_REF || cmd == CMD_MRS) begin
              if (!all_idle) begin
                ill = 1'b1;
              end else if (cmd == CMD_REF) begin
                dev_nxt = DS_REFRESH;
                cnt_nxt = CNT_W'(RFC_CYC - 1);
              end else begin
                dev_nxt = DS_MRS;
                cnt_nxt = CNT_W'(MRS_CYC - 1);
                if (BA == 2'b00) begin
                  mode_nxt = ADDR[MODE_W-1:0];
                end
              end
            end else if (cmd == CMD_ACT) begin
              if (rrd_r != '0) begin
                ill = 1'b1;
              end
              rrd_nxt = BCNT_W'(RRD_CYC - 1);
            end
          end
        end
      end
      DS_REFRESH, DS_MRS, DS_SR_EXIT, DS_DPD_EXIT: begin
        // Exit periods time out even if clock enable wobbles
        ill = !is_nop;
        if (cnt_r <= CNT_W'(1)) begin
          dev_nxt = DS_NORMAL;
        end else begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end
      end
      DS_SELF_REF: begin
        if (cke_prev_r) begin
          ill = 1'b1;
        end else if (CKE) begin
          dev_nxt = DS_SR_EXIT;
          cnt_nxt = CNT_W'(XSR_CYC - 1);
          ill     = !is_nop;
        end
      end
      DS_PWR_DOWN: begin
        if (cke_prev_r) begin
          ill = 1'b1;
        end else if (CKE) begin
          dev_nxt = DS_NORMAL;
          ill     = !is_nop;
        end
      end
      DS_DEEP_PD: begin
        if (cke_prev_r) begin
          ill = 1'b1;
        end else if (CKE) begin
          dev_nxt = DS_DPD_EXIT;
          cnt_nxt = CNT_W'(DPD_EXIT - 1);
          ill     = !is_nop;
        end
      end
      DS_SUSPEND: begin
        if (CKE) begin
          dev_nxt = DS_NORMAL;
        end
      end
      default: dev_nxt = DS_NORMAL;
    endcase
    if (bank_go && bank_ill) begin
      ill = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      dev_r      <= DS_NORMAL;
      cnt_r      <= '0;
      rrd_r      <= '0;
      mode_r     <= MODE_RST;
      cke_prev_r <= 1'b0;
      ill_r      <= 1'b0;
    end else begin
      dev_r      <= dev_nxt;
      cnt_r      <= cnt_nxt;
      rrd_r      <= rrd_nxt;
      mode_r     <= mode_nxt;
      cke_prev_r <= CKE;
      ill_r      <= ill;
    end
  end

  // Bank timers freeze while the internal clock is gated off
  for (genvar i = 0; i < NUM_BANKS; i++) begin : g_bank
    sdb_bank_if bif ();
    assign bif.en        = cke_prev_r;
    assign bif.cmd       = bank_go ? cmd : CMD_NOP;
    assign bif.hit       = (BA == 2'(i)) ||
                           (cmd == CMD_PRE && ADDR[AUTO_CLOSE_BIT]);
    assign bif.a10       = ADDR[AUTO_CLOSE_BIT];
    assign bif.bl        = bl;
    assign bif.wr_single = mode_r[WB_BIT];
    assign idle_v[i]     = (bif.st == BS_IDLE);
    assign ill_v[i]      = bif.ill;
    assign BANK_STATE[i*BST_W +: BST_W] = bif.st;
    sdb_bank u_bank (
      .clk   (REF_CLK),
      .rst_b (RST_B),
      .b     (bif)
    );
  end

  assign DEV_STATE      = dev_r;
  assign ALL_BANKS_IDLE = all_idle;
  assign CLK_ACTIVE     = cke_prev_r;
  assign CMD_ILLEGAL    = ill_r;
endmodule

// *** sdb_host.sv ***
// Command-issuing controller model for the DRAM bank-state block.
// Assumes the bench calls issue; pins change only after a rising edge.
`timescale 1ns/1ps
module sdb_host (
  input  wire logic        clk,
  output logic             cke,
  output logic [3:0]       pins,
  output logic [1:0]       ba,
  output logic [10:0]      addr
);
  initial begin
    cke  = 1'b0;
    pins = 4'hf;
    ba   = 2'h0;
    addr = 11'h000;
  end

  // Pins are {chip select, row strobe, column strobe, write enable}
  // Early access, early close and tight activates never sent
  // Low-power and mode entries only from all idle
  task automatic issue(input logic [3:0] p, input logic [1:0] b,
                       input logic [10:0] a, input logic k);
    @(posedge clk);
    cke  <= k;
    pins <= p;
    ba   <= b;
    addr <= a;
    @(posedge clk);
    // Deselect after every command, so exit edges see no-ops
    // Lines left floating are flipped so a stale value is never taken
    pins <= {1'b1, ~p[2:0]};
    ba   <= ~b;
    addr <= ~a;
    #1;
  endtask
endmodule

// *** sdb_ctrl_props.sv ***
// Concurrent checks on the bank-state and clock-enable block.
// Assumes single clock REF_CLK and async active-low RST_B.
`timescale 1ns/1ps
module sdb_ctrl_props
  import sdb_pkg::*;
#(
  parameter int NUM_BANKS = 4,
  parameter int DPD_EXIT  = DPD_CYC
) (
  input  wire logic                           REF_CLK,
  input  wire logic                           RST_B,
  input  wire logic                           CKE,
  input  wire logic                           CS_B,
  input  wire logic                           RAS_B,
  input  wire logic                           CAS_B,
  input  wire logic                           WE_B,
  input  wire logic [1:0]                     BA,
  input  wire logic [10:0]                    ADDR,
  input  wire logic [NUM_BANKS*sdb_pkg::BST_W-1:0] BANK_STATE,
  input  wire logic [3:0]                     DEV_STATE,
  input  wire logic                           ALL_BANKS_IDLE,
  input  wire logic                           CLK_ACTIVE,
  input  wire logic                           CMD_ILLEGAL
);
  logic             nopc, act, rd, wr, pre, rf, mode_register_set, norm, low;
  logic [3:0]       b0;
  logic [CNT_W-1:0] dpd_cnt_r, dpd_cnt_nxt;

  assign nopc = CS_B | (RAS_B & CAS_B & WE_B);
  assign act  = !CS_B & !RAS_B & CAS_B & WE_B;
  assign rd   = !CS_B & RAS_B & !CAS_B & WE_B;
  assign wr   = !CS_B & RAS_B & !CAS_B & !WE_B;
  assign pre  = !CS_B & !RAS_B & CAS_B & !WE_B;
  assign rf   = !CS_B & !RAS_B & !CAS_B & WE_B;
  assign mode_register_set  = !CS_B & !RAS_B & !CAS_B & !WE_B;
  assign norm = DEV_STATE == DS_NORMAL && CLK_ACTIVE && CKE;
  assign low  = DEV_STATE == DS_NORMAL && CLK_ACTIVE && !CKE;
  assign b0   = BANK_STATE[3:0];

  // Counts cycles spent in the deep power down exit wait
  always_comb begin
    dpd_cnt_nxt = (DEV_STATE == DS_DPD_EXIT) ? dpd_cnt_r + 12'h001 : 12'h000;
  end
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) dpd_cnt_r <= 12'h000;
    else        dpd_cnt_r <= dpd_cnt_nxt;
  end

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  a_act_opens: assert property (norm && act && BA == 2'h0 && b0 == BS_IDLE
    |=> b0 == BS_ACTIVE) else $error("activate did not open bank");
  a_write_restart: assert property (norm && wr && BA == 2'h0 &&
    (b0 == BS_WRITE || b0 == BS_WR_REC) |=> b0 ==
    ($past(ADDR[10]) ? BS_WRITE_AC : BS_WRITE)) else $error("write restart");
  a_pre_ends: assert property (norm && pre && BA == 2'h0 &&
    b0 == BS_WRITE |=> b0 == BS_IDLE) else $error("precharge in write");
  a_busy_refused: assert property (norm && (act || rd || wr || pre) &&
    BA == 2'h0 && (b0 == BS_WRITE_AC || b0 == BS_WR_REC_AC)
    |=> CMD_ILLEGAL) else $error("busy bank accepted command");
  a_ref_refused: assert property (norm && (rf || mode_register_set) && !ALL_BANKS_IDLE
    |=> CMD_ILLEGAL) else $error("refresh or mode set not refused");
  a_mode_idle: assert property (norm && mode_register_set && ALL_BANKS_IDLE
    |=> DEV_STATE == DS_MRS ##1 DEV_STATE == DS_NORMAL)
    else $error("mode access length wrong");
  a_self_entry: assert property (low && rf && ALL_BANKS_IDLE
    |=> DEV_STATE == DS_SELF_REF) else $error("self refresh entry");
  a_pd_entry: assert property (low && nopc && ALL_BANKS_IDLE
    |=> DEV_STATE == DS_PWR_DOWN) else $error("power down entry");
  a_self_exit: assert property (DEV_STATE == DS_SELF_REF && CKE && nopc
    |=> DEV_STATE == DS_SR_EXIT [*2] ##1 DEV_STATE == DS_NORMAL)
    else $error("self refresh exit");
  a_pd_exit: assert property (DEV_STATE == DS_PWR_DOWN && CKE
    |=> ($past(nopc) ? DEV_STATE == DS_NORMAL : CMD_ILLEGAL))
    else $error("power down exit");
  a_suspend_hold: assert property (DEV_STATE == DS_SUSPEND && !CKE
    |=> $stable(BANK_STATE)) else $error("banks moved in suspend");
  a_dpd_entry: assert property (low && ALL_BANKS_IDLE && !CS_B && RAS_B &&
    CAS_B && !WE_B |=> DEV_STATE == DS_DEEP_PD) else $error("deep entry");
  a_dpd_done: assert property (DEV_STATE == DS_DPD_EXIT &&
    dpd_cnt_r == DPD_EXIT - 2 |=> DEV_STATE == DS_NORMAL)
    else $error("deep exit length wrong");

  c_self: cover property (DEV_STATE == DS_SR_EXIT);
  c_suspend: cover property (DEV_STATE == DS_SUSPEND);
  c_refused: cover property (CMD_ILLEGAL);
endmodule

bind sdb_ctrl sdb_ctrl_props #(.NUM_BANKS(NUM_BANKS), .DPD_EXIT(DPD_EXIT))
  props_u (.REF_CLK(REF_CLK), .RST_B(RST_B), .CKE(CKE), .CS_B(CS_B),
           .RAS_B(RAS_B), .CAS_B(CAS_B), .WE_B(WE_B), .BA(BA), .ADDR(ADDR),
           .BANK_STATE(BANK_STATE), .DEV_STATE(DEV_STATE),
           .ALL_BANKS_IDLE(ALL_BANKS_IDLE), .CLK_ACTIVE(CLK_ACTIVE),
           .CMD_ILLEGAL(CMD_ILLEGAL));

// *** test_sdb_ctrl.sv ***
// Self-checking bench for the bank-state and clock-enable block.
// Assumes sdb_host drives the pins; deep exit shortened by DPD.
`timescale 1ns/1ps
module test_sdb_ctrl;
  import sdb_pkg::*;
  localparam int DPD = 5;
  localparam logic [3:0] NO_OPERATION = 4'h7, ACT = 4'h3, RD = 4'h5, WR = 4'h4;
  localparam logic [3:0] PRE = 4'h2, REF = 4'h1, MODE_REGISTER_SET = 4'h0, DPE = 4'h6;
  logic        ref_clk, rst_b, cke, all_idle, clk_act, illegal;
  logic [3:0]  pins, dev;
  logic [1:0]  ba;
  logic [10:0] addr;
  logic [15:0] bst;
  int          mismatches, checks, cyc;

  sdb_host host_u (.clk(ref_clk), .cke(cke), .pins(pins), .ba(ba),
                   .addr(addr));
  sdb_ctrl #(.DPD_EXIT(DPD)) dut_u (.REF_CLK(ref_clk), .RST_B(rst_b),
    .CKE(cke), .CS_B(pins[3]), .RAS_B(pins[2]), .CAS_B(pins[1]),
    .WE_B(pins[0]), .BA(ba), .ADDR(addr), .BANK_STATE(bst),
    .DEV_STATE(dev), .ALL_BANKS_IDLE(all_idle), .CLK_ACTIVE(clk_act),
    .CMD_ILLEGAL(illegal));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [3:0] bk(input int i);
    return bst[4*i +: 4];
  endfunction
  task automatic go(input logic [3:0] p, input logic [1:0] b,
                    input logic [10:0] a, input logic k = 1'b1);
    host_u.issue(p, b, a, k);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Bounded wait; auto-close recovery must finish well inside it
  task automatic wait_idle(input int i);
    for (int n = 0; n < 40 && bk(i) !== BS_IDLE; n++) wait_cyc(1);
  endtask

  task automatic t_row_cycle;
    go(ACT, 2'h0, 11'h000);
    chk(bk(0), BS_ACTIVE);
    go(WR, 2'h0, 11'h000);
    chk(bk(0), BS_WRITE);
    wait_cyc(1);
    chk(bk(0), BS_WR_REC);
    wait_cyc(1);
    chk(bk(0), BS_ACTIVE);
    go(PRE, 2'h0, 11'h000);
    chk(bk(0), BS_IDLE);
    $display("row cycle done");
  endtask

  task automatic t_busy_device;
    go(REF, 2'h0, 11'h000);
    chk(dev, DS_REFRESH);
    chk(illegal, 1'b0);
    go(ACT, 2'h0, 11'h000);
    chk(illegal, 1'b1);
    chk(bk(0), BS_IDLE);
    go(MODE_REGISTER_SET, 2'h0, 11'h003);
    chk(dev, DS_MRS);
    wait_cyc(1);
    chk(dev, DS_NORMAL);
    $display("busy device done");
  endtask

  task automatic t_burst_cut;
    go(ACT, 2'h1, 11'h000);
    go(WR, 2'h1, 11'h000);
    chk(bk(1), BS_WRITE);
    go(REF, 2'h0, 11'h000);
    chk(illegal, 1'b1);
    go(WR, 2'h1, 11'h400);
    chk(bk(1), BS_WRITE_AC);
    go(ACT, 2'h2, 11'h000);
    chk(bk(2), BS_ACTIVE);
    go(PRE, 2'h1, 11'h000);
    chk(illegal, 1'b1);
    chk(bk(1), BS_WRITE_AC);
    go(WR, 2'h2, 11'h000);
    go(RD, 2'h2, 11'h000);
    chk(bk(2), BS_READ);
    go(PRE, 2'h2, 11'h000);
    chk(bk(2), BS_IDLE);
    go(ACT, 2'h3, 11'h000);
    go(WR, 2'h3, 11'h000);
    go(PRE, 2'h3, 11'h000);
    chk(bk(3), BS_IDLE);
    wait_idle(1);
    chk(bk(1), BS_IDLE);
    $display("burst cut done");
  endtask

  task automatic t_recovery;
    go(MODE_REGISTER_SET, 2'h0, 11'h203);
    wait_cyc(1);
    go(ACT, 2'h0, 11'h000);
    go(WR, 2'h0, 11'h000);
    go(WR, 2'h0, 11'h400);
    chk(bk(0), BS_WRITE_AC);
    wait_idle(0);
    chk(bk(0), BS_IDLE);
    $display("recovery done");
  endtask

  task automatic t_suspend;
    go(ACT, 2'h0, 11'h000);
    go(RD, 2'h0, 11'h000);
    go(NO_OPERATION, 2'h0, 11'h000, 1'b0);
    chk(dev, DS_SUSPEND);
    chk(all_idle, 1'b0);
    wait_cyc(10);
    chk(bk(0), BS_READ);
    go(NO_OPERATION, 2'h0, 11'h000);
    chk(dev, DS_NORMAL);
    go(PRE, 2'h0, 11'h000);
    $display("suspend done");
  endtask

  task automatic t_low_power;
    go(REF, 2'h0, 11'h000, 1'b0);
    chk(dev, DS_SELF_REF);
    wait_cyc(3);
    chk(dev, DS_SELF_REF);
    go(NO_OPERATION, 2'h0, 11'h000);
    chk(dev, DS_SR_EXIT);
    go(NO_OPERATION, 2'h0, 11'h000);
    chk(dev, DS_NORMAL);
    go(4'hf, 2'h0, 11'h000, 1'b0);
    chk(dev, DS_PWR_DOWN);
    go(NO_OPERATION, 2'h0, 11'h000);
    chk(dev, DS_NORMAL);
    go(DPE, 2'h0, 11'h000, 1'b0);
    chk(dev, DS_DEEP_PD);
    wait_cyc(2);
    chk(dev, DS_DEEP_PD);
    go(NO_OPERATION, 2'h0, 11'h000);
    wait_cyc(DPD - 2);
    chk(dev, DS_DPD_EXIT);
    wait_cyc(1);
    chk(dev, DS_NORMAL);
    go(4'hf, 2'h0, 11'h000, 1'b0);
    go(ACT, 2'h0, 11'h000);
    chk(illegal, 1'b1);
    $display("low power done");
  endtask

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Whole run is about a hundred cycles; the ceiling leaves wide margin
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      $display("timeout at cycle %0d", cyc);
      summarize();
    end
  end

  initial begin
    rst_b = 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    go(NO_OPERATION, 2'h0, 11'h000);
    t_row_cycle();
    t_busy_device();
    t_burst_cut();
    t_recovery();
    t_suspend();
    t_low_power();
    @(posedge ref_clk);
    rst_b <= 1'b0;
    wait_cyc(1);
    chk({bst, dev}, 20'h0_0000);
    chk({clk_act, illegal}, 2'h0);
    summarize();
  end
endmodule
